// file: include/sfs_pkg.sv
// sfs_pkg: constants for the servo fault supervisor
// assumes a 100 MHz mclk and a synchronous active-high reset
package sfs_pkg;

  // ----------------------------------------
  // fault codes
  // ----------------------------------------
  localparam int          NUM_FAULTS    = 12;
  localparam logic [3:0]  CODE_HW       = 4'h0;
  localparam logic [3:0]  CODE_SUPPLY   = 4'h1;
  localparam logic [3:0]  CODE_PHASE    = 4'h2;
  localparam logic [3:0]  CODE_CABLE    = 4'h3;
  localparam logic [3:0]  CODE_LAST_FATAL = 4'h1;

  // ----------------------------------------
  // measurement thresholds
  // ----------------------------------------
  localparam logic [15:0] DC_LINK_MAX_V = 16'd480;
  // current scaled in tenths: limit is 25/10 of rated
  localparam logic [7:0]  CUR_NUM       = 8'd25;
  localparam logic [7:0]  CUR_DEN       = 8'd10;
  // speed limit is 5/4 of configured maximum
  localparam logic [7:0]  SPD_NUM       = 8'd5;
  localparam logic [7:0]  SPD_DEN       = 8'd4;

  // ----------------------------------------
  // display timing
  // ----------------------------------------
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          REFRESH_MS    = 1000;
  localparam int          REFRESH_CYC   = CLK_HZ / 1000 * REFRESH_MS;

  // seven-segment glyphs, gfedcba, active high
  localparam logic [6:0]  SEG_LETTER_F  = 7'h71;
  localparam logic [6:0]  SEG_BLANK     = 7'h00;

  typedef enum logic [1:0] {
    SFS_RUN    = 2'b00,
    SFS_LOCKED = 2'b01,
    SFS_FATAL  = 2'b10
  } sfs_state_t;

endpackage

// file: hdl/sfs_display.sv
// sfs_display: shows letter F and a two-digit fault number, refreshed once a second
// assumes code is stable while show is high
`timescale 1ns/1ps
module sfs_display
  import sfs_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // fault to show
  input  wire logic       show,
  input  wire logic [3:0] code,
  // segment outputs
  output logic [6:0]      segLetter_r,
  output logic [6:0]      segTens_r,
  output logic [6:0]      segUnits_r,
  output logic            refreshTick_r
);

  initial begin
    if (REFRESH_CYCLES < 2) $error("refresh period too short");
  end

  // ----------------------------------------
  // decimal digit to segments
  // ----------------------------------------
  function automatic logic [6:0] digitSeg(input logic [3:0] d);
    unique case (d)
      4'h0: digitSeg = 7'h3f;
      4'h1: digitSeg = 7'h06;
      4'h2: digitSeg = 7'h5b;
      4'h3: digitSeg = 7'h4f;
      4'h4: digitSeg = 7'h66;
      4'h5: digitSeg = 7'h6d;
      4'h6: digitSeg = 7'h7d;
      4'h7: digitSeg = 7'h07;
      4'h8: digitSeg = 7'h7f;
      4'h9: digitSeg = 7'h6f;
      default: digitSeg = SEG_BLANK;
    endcase
  endfunction

  logic [31:0] cnt_r, cnt_nxt;
  logic [6:0]  letter_nxt, tens_nxt, units_nxt;
  logic        tick_nxt;
  logic [3:0]  tensDig, unitsDig;

  always_comb begin
    tensDig    = (code >= 4'ha) ? 4'h1 : 4'h0;
    unitsDig   = (code >= 4'ha) ? 4'(code - 4'ha) : code;
    tick_nxt   = (cnt_r == 32'(REFRESH_CYCLES - 1));
    cnt_nxt    = tick_nxt ? 32'h0 : cnt_r + 32'h1;
    letter_nxt = segLetter_r;
    tens_nxt   = segTens_r;
    units_nxt  = segUnits_r;
    // segments only change at a refresh tick, so a new fault waits up to a second
    if (tick_nxt) begin
      letter_nxt = show ? SEG_LETTER_F : SEG_BLANK;
      tens_nxt   = show ? digitSeg(tensDig) : SEG_BLANK;
      units_nxt  = show ? digitSeg(unitsDig) : SEG_BLANK;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r         <= 32'h0;
      segLetter_r   <= SEG_BLANK;
      segTens_r     <= SEG_BLANK;
      segUnits_r    <= SEG_BLANK;
      refreshTick_r <= 1'b0;
    end else begin
      cnt_r         <= cnt_nxt;
      segLetter_r   <= letter_nxt;
      segTens_r     <= tens_nxt;
      segUnits_r    <= units_nxt;
      refreshTick_r <= tick_nxt;
    end
  end

endmodule

// file: hdl/sfs_supervisor.sv
// sfs_supervisor: latches the first fault, cuts motor power, drives the fault display
// assumes sensor flags arrive from pins (synchronised here), measurements from mclk logic
// Behaviour
// - show F and fault number, refresh each second
// - codes 00, 01 cut power, never acknowledgeable
// - code 02 phase loss, only in 3-phase
// - code 03 cable break, first enable only
// - code 04 when DC link above 480 V
// - code 05 when current above 2.5 rated
// - code 06 on ballast resistor overload
// - code 07 on amplifier overtemperature
// - code 08 on motor overtemperature
// - code 09 on encoder break or init failure
// - code 10 when speed above 1.25 max
// - code 11 on even brief current overrange
// - stay locked, power off until acknowledged
`timescale 1ns/1ps
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter int MEAS_W         = 16
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // pin-level fault flags, asynchronous
  input  wire logic              hwDefect,
  input  wire logic              supplyBad,
  input  wire logic              phaseLost,
  input  wire logic              cableBroken,
  input  wire logic              ballastOverload,
  input  wire logic              ampOverTemp,
  input  wire logic              motorOverTemp,
  input  wire logic              encoderBreak,
  input  wire logic              encoderInitFail,
  input  wire logic              currentOverrange,
  // configuration and control, asynchronous
  input  wire logic              threePhase,
  input  wire logic              driveEnable,
  input  wire logic              faultAck,
  // measurements, same clock domain
  input  wire logic [MEAS_W-1:0] dcLinkVolts,
  input  wire logic [MEAS_W-1:0] outCurrent,
  input  wire logic [MEAS_W-1:0] ratedCurrent,
  input  wire logic [MEAS_W-1:0] shaftSpeed,
  input  wire logic [MEAS_W-1:0] maxSpeed,
  // power stage and status
  output logic                   powerDisable_r,
  output logic                   faultPending_r,
  output logic [3:0]             faultCode_r,
  // display
  output logic [6:0]             segLetter_r,
  output logic [6:0]             segTens_r,
  output logic [6:0]             segUnits_r,
  output logic                   refreshTick_r
);

  localparam int NPIN = 13;

  initial begin
    if (MEAS_W < 10 || MEAS_W > 24) $error("measurement width unsupported");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pinRaw, pinMeta_r, pinSync_r;
  assign pinRaw = {faultAck, driveEnable, threePhase, currentOverrange, encoderInitFail,
                   encoderBreak, motorOverTemp, ampOverTemp, ballastOverload,
                   cableBroken, phaseLost, supplyBad, hwDefect};

  always_ff @(posedge mclk) begin
    if (srst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  // ----------------------------------------
  // fault detection
  // ----------------------------------------
  logic [NUM_FAULTS-1:0] cond;
  logic [MEAS_W+7:0]     curLhs, curRhs, spdLhs, spdRhs;
  logic                  enSync, ackSync, firstEnable;
  logic                  enPrev_r, enPrev_nxt, enabledOnce_r, enabledOnce_nxt;

  assign enSync  = pinSync_r[11];
  assign ackSync = pinSync_r[12];
  assign firstEnable = enSync && !enPrev_r && !enabledOnce_r;

  always_comb begin
    curLhs = (MEAS_W+8)'(outCurrent) * (MEAS_W+8)'(CUR_DEN);
    curRhs = (MEAS_W+8)'(ratedCurrent) * (MEAS_W+8)'(CUR_NUM);
    spdLhs = (MEAS_W+8)'(shaftSpeed) * (MEAS_W+8)'(SPD_DEN);
    spdRhs = (MEAS_W+8)'(maxSpeed) * (MEAS_W+8)'(SPD_NUM);
    cond[0]  = pinSync_r[0];
    cond[1]  = pinSync_r[1];
    cond[2]  = pinSync_r[2] && pinSync_r[10];
    // cable test only on the very first enable edge; later breaks go unseen
    cond[3]  = pinSync_r[3] && firstEnable;
    cond[4]  = dcLinkVolts > MEAS_W'(DC_LINK_MAX_V);
    cond[5]  = curLhs > curRhs;
    cond[6]  = pinSync_r[4];
    cond[7]  = pinSync_r[5];
    cond[8]  = pinSync_r[6];
    cond[9]  = pinSync_r[7] || pinSync_r[8];
    cond[10] = spdLhs > spdRhs;
    // a one-cycle overrange pulse is enough; it is latched below
    cond[11] = pinSync_r[9];
    enPrev_nxt      = enSync;
    enabledOnce_nxt = enabledOnce_r || enSync;
  end

  // lowest code wins when several faults appear in the same cycle
  function automatic logic [3:0] firstCode(input logic [NUM_FAULTS-1:0] c);
    firstCode = 4'h0;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (c[i]) firstCode = 4'(i);
    end
  endfunction

  // ----------------------------------------
  // fault latch state machine
  // ----------------------------------------
  sfs_state_t state_r, state_nxt;
  logic [3:0] code_nxt;
  logic       causeActive;

  always_comb begin
    state_nxt   = state_r;
    code_nxt    = faultCode_r;
    causeActive = cond[faultCode_r];
    unique case (state_r)
      SFS_RUN: begin
        if (|cond) begin
          code_nxt  = firstCode(cond);
          state_nxt = (firstCode(cond) <= CODE_LAST_FATAL) ? SFS_FATAL : SFS_LOCKED;
        end
      end
      SFS_LOCKED: begin
        // ack clears only once the cause is gone; the controller waits for cooling
        if (ackSync && !causeActive) begin
          state_nxt = SFS_RUN;
          code_nxt  = 4'h0;
        end
      end
      SFS_FATAL: begin
        state_nxt = SFS_FATAL;
      end
      default: state_nxt = SFS_LOCKED;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r        <= SFS_RUN;
      faultCode_r    <= 4'h0;
      powerDisable_r <= 1'b0;
      faultPending_r <= 1'b0;
      enPrev_r       <= 1'b0;
      enabledOnce_r  <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      faultCode_r    <= code_nxt;
      powerDisable_r <= (state_nxt != SFS_RUN);
      faultPending_r <= (state_nxt != SFS_RUN);
      enPrev_r       <= enPrev_nxt;
      enabledOnce_r  <= enabledOnce_nxt;
    end
  end

  // ----------------------------------------
  // display
  // ----------------------------------------
  sfs_display #(.REFRESH_CYCLES(REFRESH_CYCLES)) uDisplay (
    .mclk          (mclk),
    .srst          (srst),
    .show          (faultPending_r),
    .code          (faultCode_r),
    .segLetter_r   (segLetter_r),
    .segTens_r     (segTens_r),
    .segUnits_r    (segUnits_r),
    .refreshTick_r (refreshTick_r)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence faultSeen;
    state_r == SFS_RUN && |cond;
  endsequence

  sequence lockedWithCode(logic [3:0] c);
    powerDisable_r && faultCode_r == c;
  endsequence

  chk_fault_cuts_power: assert property (@(posedge mclk) disable iff (srst)
    faultSeen |=> lockedWithCode($past(firstCode(cond))))
    else $error("fault did not cut power with its code");

  chk_fatal_stays: assert property (@(posedge mclk) disable iff (srst)
    state_r == SFS_FATAL |=> state_r == SFS_FATAL && powerDisable_r)
    else $error("fatal fault left locked state");

  chk_ack_blocked: assert property (@(posedge mclk) disable iff (srst)
    state_r == SFS_LOCKED && causeActive |=> powerDisable_r)
    else $error("ack accepted while cause present");

  chk_ack_release: assert property (@(posedge mclk) disable iff (srst)
    state_r == SFS_LOCKED && ackSync && !causeActive |=> !powerDisable_r)
    else $error("valid ack did not release");

  // a valid ack clears the code, so only cycles that keep the lock are checked
  chk_code_held: assert property (@(posedge mclk) disable iff (srst)
    state_r == SFS_FATAL || (state_r == SFS_LOCKED && !(ackSync && !causeActive))
    |=> faultCode_r == $past(faultCode_r))
    else $error("latched code changed");

  // cond[2] is left out of the antecedent so an ungated phase check would trip this
  chk_phase_gated: assert property (@(posedge mclk) disable iff (srst)
    state_r == SFS_RUN && !pinSync_r[10] && !(|cond[1:0]) && !(|cond[11:3])
    |=> !powerDisable_r)
    else $error("phase fault raised in single phase");

  chk_dc_link: assert property (@(posedge mclk) disable iff (srst)
    state_r == SFS_RUN && dcLinkVolts > MEAS_W'(DC_LINK_MAX_V) && !(|cond[3:0])
    |=> faultCode_r == 4'h4)
    else $error("dc link overvoltage missed");

  chk_brief_overrange: assert property (@(posedge mclk) disable iff (srst)
    state_r == SFS_RUN && cond[11] && !(|cond[10:0]) |=> ##[0:3] faultCode_r == 4'hb)
    else $error("current overrange missed");

  chk_display_f: assert property (@(posedge mclk) disable iff (srst)
    refreshTick_r && faultPending_r && $past(faultPending_r) |-> segLetter_r == SEG_LETTER_F)
    else $error("letter not shown on refresh");

endmodule

// file: testbench/sfs_partner.sv
// sfs_partner: sensors, power stage measurements and supervising controller
// assumes the bench sets its variables just after a falling edge
`timescale 1ns/1ps
module sfs_partner (
  // clock
  input  wire logic   mclk,
  // pin flags, hwDefect at bit 0 up to currentOverrange at bit 9
  output logic [9:0]  pinFlags,
  output logic        threePhase,
  output logic        driveEnable,
  // measurements
  output logic [15:0] dcLinkVolts,
  output logic [15:0] outCurrent,
  output logic [15:0] ratedCurrent,
  output logic [15:0] shaftSpeed,
  output logic [15:0] maxSpeed,
  // controller
  output logic        faultAck
);
  logic       ackReq;
  logic [2:0] ackCnt;
  initial begin
    pinFlags = 10'h000;
    threePhase = 1'b0;
    driveEnable = 1'b0;
    dcLinkVolts = 16'h0000;
    outCurrent = 16'h0000;
    ratedCurrent = 16'h000a;
    shaftSpeed = 16'h0000;
    maxSpeed = 16'h0004;
    ackReq = 1'b0;
    ackCnt = 3'h0;
  end
  // --------------------------------
  // acknowledge
  // --------------------------------
  // held 4 cycles so the two-flop synchroniser cannot miss it
  always @(negedge mclk) begin
    if (ackCnt != 3'h0) begin
      ackCnt <= ackCnt - 3'h1;
    end else if (ackReq && pinFlags[6:4] == 3'h0) begin
      ackCnt <= 3'h4;
      ackReq <= 1'b0;
    end
  end
  assign faultAck = (ackCnt != 3'h0);
endmodule

// file: testbench/servo_fault_supervisor_tb.sv
// servo_fault_supervisor_tb: self-checking bench for the fault supervisor
// assumes sfs_partner stands in for the sensors and the controller
`timescale 1ns/1ps
module servo_fault_supervisor_tb
  import sfs_pkg::*;
;
  logic        mclk;
  logic        srst;
  logic [9:0]  fl;
  logic        tp, de, ack, pd, fp, tick;
  logic [15:0] dc, cur, rat, spd, mx;
  logic [3:0]  code;
  logic [6:0]  sL, sT, sU;
  int          fails;
  int          checks;

  sfs_partner p_u (.mclk(mclk), .pinFlags(fl), .threePhase(tp), .driveEnable(de),
    .dcLinkVolts(dc), .outCurrent(cur), .ratedCurrent(rat), .shaftSpeed(spd),
    .maxSpeed(mx), .faultAck(ack));
  sfs_supervisor #(.REFRESH_CYCLES(16), .MEAS_W(16)) dut_u (.mclk(mclk), .srst(srst),
    .hwDefect(fl[0]), .supplyBad(fl[1]), .phaseLost(fl[2]), .cableBroken(fl[3]),
    .ballastOverload(fl[4]), .ampOverTemp(fl[5]), .motorOverTemp(fl[6]),
    .encoderBreak(fl[7]), .encoderInitFail(fl[8]), .currentOverrange(fl[9]),
    .threePhase(tp), .driveEnable(de), .faultAck(ack), .dcLinkVolts(dc),
    .outCurrent(cur), .ratedCurrent(rat), .shaftSpeed(spd), .maxSpeed(mx),
    .powerDisable_r(pd), .faultPending_r(fp), .faultCode_r(code), .segLetter_r(sL),
    .segTens_r(sT), .segUnits_r(sU), .refreshTick_r(tick));

  always #5 mclk = ~mclk;
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic waitPd(input logic v);
    int n;
    n = 0;
    while (pd !== v && n < 12) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic waitTick(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // ack pulse outlasts the release, so let it drain before the next fault
  task automatic ackWait();
    p_u.ackReq = 1'b1;
    waitPd(1'b0);
    check(pd, 1'b0);
    check(fp, 1'b0);
    check(code, 4'h0);
    repeat (6) @(negedge mclk);
  endtask
  task automatic pinFault(input int i, input logic [3:0] cd);
    p_u.pinFlags[i] = 1'b1;
    waitPd(1'b1);
    check(pd, 1'b1);
    check(code, cd);
    check(fp, 1'b1);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_cable();
    p_u.driveEnable = 1'b1;
    pinFault(3, 4'h3);
    p_u.pinFlags[3] = 1'b0;
    ackWait();
    p_u.driveEnable = 1'b0;
    p_u.pinFlags[3] = 1'b1;
    repeat (4) @(negedge mclk);
    p_u.driveEnable = 1'b1;
    repeat (10) @(negedge mclk);
    check(pd, 1'b0);
    p_u.pinFlags[3] = 1'b0;
    $display("test cable done");
  endtask
  task automatic t_pins();
    int idx [7] = '{2, 4, 5, 6, 7, 8, 9};
    logic [3:0] cd [7] = '{4'h2, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'hb};
    p_u.threePhase = 1'b1;
    for (int i = 0; i < 7; i++) begin
      pinFault(idx[i], cd[i]);
      p_u.pinFlags[idx[i]] = 1'b0;
      ackWait();
    end
    p_u.threePhase = 1'b0;
    p_u.pinFlags[2] = 1'b1;
    repeat (8) @(negedge mclk);
    check(pd, 1'b0);
    p_u.pinFlags[2] = 1'b0;
    $display("test pins done");
  endtask
  task automatic t_meas(input int sel, input logic [15:0] lo, input logic [15:0] hi,
                        input logic [3:0] cd);
    for (int k = 0; k < 3; k++) begin
      case (sel)
        0: p_u.dcLinkVolts = (k == 0) ? lo : (k == 1) ? hi : 16'h0000;
        1: p_u.outCurrent = (k == 0) ? lo : (k == 1) ? hi : 16'h0000;
        default: p_u.shaftSpeed = (k == 0) ? lo : (k == 1) ? hi : 16'h0000;
      endcase
      if (k == 0) begin
        repeat (4) @(negedge mclk);
        check(pd, 1'b0);
      end else if (k == 1) begin
        waitPd(1'b1);
        check(code, cd);
      end
    end
    ackWait();
    $display("test measurement %0d done", sel);
  endtask
  task automatic t_latch();
    p_u.pinFlags[6:5] = 2'b11;
    pinFault(5, 4'h7);
    p_u.pinFlags[6:5] = 2'b00;
    ackWait();
    pinFault(7, 4'h9);
    p_u.ackReq = 1'b1;
    p_u.pinFlags[9] = 1'b1;
    repeat (12) @(negedge mclk);
    check(code, 4'h9);
    p_u.pinFlags[7] = 1'b0;
    p_u.ackReq = 1'b1;
    repeat (12) @(negedge mclk);
    check(code, 4'hb);
    p_u.pinFlags[9] = 1'b0;
    ackWait();
    $display("test latch done");
  endtask
  task automatic t_disp();
    int n;
    p_u.shaftSpeed = 16'h0006;
    waitPd(1'b1);
    waitTick(n);
    @(negedge mclk);
    waitTick(n);
    check(16'(n + 1), 16'h0010);
    @(negedge mclk);
    check({sL, sT}, {2'h0, 7'h71, 7'h06});
    check(sU, 7'h3f);
    p_u.shaftSpeed = 16'h0000;
    ackWait();
    waitTick(n);
    @(negedge mclk);
    check(sL, 7'h00);
    $display("test display done");
  endtask
  task automatic t_fatal();
    for (int j = 0; j < 2; j++) begin
      pinFault(j, 4'(j));
      p_u.pinFlags[j] = 1'b0;
      p_u.ackReq = 1'b1;
      repeat (12) @(negedge mclk);
      check(pd, 1'b1);
      srst = 1'b1;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      repeat (3) @(negedge mclk);
      check(pd, 1'b0);
    end
    $display("test fatal done");
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // --------------------------------
  // main sequence and watchdog
  // --------------------------------
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    fails = 0;
    checks = 0;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
    t_cable();
    t_pins();
    t_meas(0, 16'h01e0, 16'h01e1, 4'h4);
    t_meas(1, 16'h0019, 16'h001a, 4'h5);
    t_meas(2, 16'h0005, 16'h0006, 4'ha);
    t_latch();
    t_disp();
    t_fatal();
    end_of_test();
  end
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule
